// File: shared/nep_pkg.sv
// Constants and carrier types for the Ethernet packet access port.
// Assumes one system clock; all lanes and the MAC side share it.
package nep_pkg;
  // ********************************************************************
  // Geometry
  // ********************************************************************
  localparam int NEP_LANES = 4;
  localparam int NEP_BYTES = 32;
  localparam int NEP_SEQ_LSB = 9;
  localparam int NEP_SEQ_W = 5;
  // ********************************************************************
  // Transmit flag positions inside the sideband field
  // ********************************************************************
  localparam int NEP_F_ERR = 18;
  localparam int NEP_F_INS = 19;
  localparam int NEP_F_INV = 20;
  localparam int NEP_F_OVR = 21;
  localparam logic [3:0] NEP_UNIT_ID = 4'hf;
  localparam logic [31:0] NEP_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] NEP_CRC_POLY = 32'hedb88320;
  localparam logic [5:0] NEP_FCS_BYTES = 6'h04;
  // ********************************************************************
  // Registers (byte addresses) and control bits
  // ********************************************************************
  localparam logic [7:0] NEP_REG_CTRL = 8'h00;
  localparam logic [7:0] NEP_REG_STAT = 8'h04;
  localparam logic [7:0] NEP_REG_CNT = 8'h08;
  localparam int NEP_C_WHOLE = 0;
  localparam int NEP_C_HALF = 1;
  localparam int NEP_C_RXTS = 2;
  localparam int NEP_C_ONESTEP = 3;
  localparam logic [3:0] NEP_CTRL_RST = 4'h0;

  typedef struct packed {
    logic [1:0] unused;
    logic [29:0] sb;
    logic [4:0] mod;
    logic [255:0] data;
  } nep_word_t;

  typedef struct packed {
    logic sop;
    logic eop;
    nep_word_t w;
  } nep_beat_t;

  typedef struct packed {
    logic append;
    logic overwrite;
    logic corrupt;
    logic onestep;
    logic [29:0] ts;
    logic [31:0] crc;
  } nep_fcs_t;
endpackage

// File: hdl/nep_port.sv
// Four-lane Ethernet packet access port between user logic and the MAC.
// Assumes user lanes and the MAC side run on sys_clk_i; registers are
// reached over classic Wishbone.
// Functional notes
// (RQ1) Quad segmented mode: four lanes form one 1024-bit bus, one stream.
// (RQ2) Quad mode: each new packet starts on the lane after the last one.
// (RQ3) Whole-packet mode: each lane carries complete packets independently.
// (RQ4) Whole-packet mode: next packet goes to a lane that is not busy.
// (RQ5) Whole-packet mode: no ordering is promised across separate lanes.
// (RQ6) Asynchronous reset clears the port logic only.
// (RQ7) Every port is synchronous to the one interface clock.
// (RQ8) Transmit: device raises ready when it can take; user raises valid.
// (RQ9) A word moves only on an edge with valid and ready both high.
// (RQ10) User drives transmit destination to all ones.
// (RQ11) User marks first and last word of every transmit packet.
// (RQ12) Word layout: data 255:0, remainder 260:256, sideband 290:261.
// (RQ13) Receive: user raises ready; device raises valid with each word.
// (RQ14) Receive word uses the same layout as transmit.
// (RQ15) On a start word the sideband carries a timestamp, not flags.
// (RQ16) Transmit timestamp on first word is captured for one-step update.
// (RQ17) Receive arrival timestamp is presented on the receive start word.
// (RQ18) Transmit sideband 16:0 is update vector, bit 17 marks event frame.
// (RQ19) Transmit error flag forces a bad CRC or flips a check-field bit.
// (RQ20) CRC-insert flag appends a 4-byte check field, else none.
// (RQ21) Invert flag inverts CRC when insert or override is set.
// (RQ22) Override replaces existing CRC only while insert is clear.
// (RQ23) Sideband bits 22/23 mark class A/B; bits 29:24 are zero.
// (RQ24) Receive non-start words carry a sequence number in bits 13:9.
// (RQ25) Override computes fresh CRC-32 over frame data, inverted if asked.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module nep_port
  import nep_pkg::*;
(
  input wire logic sys_clk_i, // 250 MHz clock
  input wire logic rst_i, // Async reset, high
  input wire logic [7:0] wb_adr_i, // Wishbone address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic wb_we_i, // Wishbone write
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [3:0] tx_valid_i, // Per-lane transmit valid
  input wire logic [3:0] tx_sop_i, // Per-lane start of packet
  input wire logic [3:0] tx_eop_i, // Per-lane end of packet
  input wire logic [3:0][3:0] tx_dest_i, // Per-lane destination
  input wire nep_pkg::nep_word_t [3:0] tx_data_i, // Per-lane word
  output logic [3:0] tx_ready_o, // Per-lane transmit ready
  output nep_pkg::nep_beat_t mac_tx_o, // Word toward MAC
  output logic mac_tx_valid_o, // MAC word valid
  input wire logic mac_tx_ready_i, // MAC takes word
  output nep_pkg::nep_fcs_t mac_fcs_o, // Check field action
  input wire nep_pkg::nep_beat_t mac_rx_i, // Word from MAC
  input wire logic mac_rx_valid_i, // MAC word valid
  output logic mac_rx_ready_o, // Port takes MAC word
  input wire logic [29:0] ts_count_i, // Arrival time count
  output logic [3:0] rx_valid_o, // Per-lane receive valid
  output logic [3:0] rx_sop_o, // Per-lane start of packet
  output logic [3:0] rx_eop_o, // Per-lane end of packet
  output logic [3:0] rx_src_o, // Source id, all lanes
  output nep_pkg::nep_word_t [3:0] rx_data_o, // Per-lane word
  input wire logic [3:0] rx_ready_i // Per-lane receive ready
);
  import nep_pkg::*;

  typedef struct packed {
    logic [3:0] ctrl;
    logic ack;
    logic [31:0] dat;
    logic [1:0] tx_ptr;
    logic tx_lock;
    logic [1:0] tx_lane;
    logic [3:0] tx_rdy;
    logic [31:0] crc;
    nep_beat_t mtx;
    logic mtx_v;
    nep_fcs_t fcs;
    logic [1:0] rx_ptr;
    logic rx_lock;
    logic [1:0] rx_tgt;
    logic mrx_rdy;
    logic [4:0] seq;
    logic [3:0] rx_v;
    logic [3:0] rx_sop;
    logic [3:0] rx_eop;
    nep_word_t [3:0] rx_w;
    logic [3:0] src;
    logic [15:0] txcnt;
    logic [15:0] rxcnt;
  } nep_state_t;

  nep_state_t q;
  nep_state_t n;

  function automatic logic [1:0] lane_inc(input logic [1:0] l,
                                          input logic half);
    lane_inc = (half && l == 2'h1) ? 2'h0 : l + 2'h1;
  endfunction

  // Byte 0 sits in data[7:0] and goes out first, LSB first
  function automatic logic [31:0] crc_bytes(input logic [31:0] c,
                                            input logic [255:0] d,
                                            input logic [5:0] nb);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < NEP_BYTES; i++) begin
      if (i < int'(nb)) begin
        for (int b = 0; b < 8; b++) begin
          r = (r >> 1) ^ ((r[0] ^ d[i*8+b]) ? NEP_CRC_POLY : 32'h0);
        end
      end
    end
    crc_bytes = r;
  endfunction

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    nep_word_t w;
    logic [1:0] l;
    logic [1:0] k;
    logic [5:0] nb;
    logic [5:0] nbc;
    logic [31:0] c;
    logic [31:0] cv;
    logic whole;
    logic half;
    logic found;
    w = '0;
    l = 2'h0;
    k = 2'h0;
    nb = 6'h0;
    nbc = 6'h0;
    c = 32'h0;
    cv = 32'h0;
    whole = q.ctrl[NEP_C_WHOLE];
    half = q.ctrl[NEP_C_HALF];
    found = 1'b0;
    n = q;
    n.src = NEP_UNIT_ID;

    // ****************************************************************
    // Register slave: one wait state, unmapped reads return zero
    // ****************************************************************
    n.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      n.ack = 1'b1;
      unique case (wb_adr_i)
        NEP_REG_CTRL: begin
          n.dat = {28'h0, q.ctrl};
          if (wb_we_i && wb_sel_i[0]) begin
            n.ctrl = wb_dat_i[3:0];
          end
        end
        NEP_REG_STAT: n.dat = {21'h0, q.seq, q.rx_lock, q.rx_ptr,
                               q.tx_lock, q.tx_ptr};
        NEP_REG_CNT: n.dat = {q.rxcnt, q.txcnt};
        default: n.dat = 32'h0;
      endcase
    end

    // ****************************************************************
    // Transmit: lanes to MAC
    // ****************************************************************
    if (q.mtx_v && mac_tx_ready_i) begin // [RQ9]
      n.mtx_v = 1'b0;
    end
    if (|(q.tx_rdy & tx_valid_i)) begin // [RQ9]
      l = q.tx_lane;
      w = tx_data_i[l]; // [RQ12]
      nb = (tx_eop_i[l] && w.mod != 5'h0) ? {1'b0, w.mod} : 6'(NEP_BYTES);
      nbc = nb;
      c = tx_sop_i[l] ? NEP_CRC_INIT : q.crc;
      // Override recomputes over data without the old check field;
      // that field must lie wholly in the last word.
      if (tx_eop_i[l] && !tx_sop_i[l] && !w.sb[NEP_F_INS] &&
          w.sb[NEP_F_OVR]) begin // [RQ25]
        nbc = (nb >= NEP_FCS_BYTES) ? nb - NEP_FCS_BYTES : 6'h0;
      end
      c = crc_bytes(c, w.data, nbc);
      n.crc = c;
      if (tx_sop_i[l]) begin
        n.fcs.ts = w.sb; // [RQ15] [RQ16]
        n.fcs.onestep = q.ctrl[NEP_C_ONESTEP];
      end
      if (tx_eop_i[l]) begin
        n.fcs.append = 1'b0;
        n.fcs.overwrite = 1'b0;
        n.fcs.corrupt = 1'b0;
        n.fcs.crc = 32'h0;
        if (!tx_sop_i[l]) begin // [RQ18] [RQ23] flags only off the start
          cv = ~c;
          if (w.sb[NEP_F_INV] && (w.sb[NEP_F_INS] || w.sb[NEP_F_OVR])) begin
            cv = ~cv; // [RQ21]
          end
          n.fcs.append = w.sb[NEP_F_INS]; // [RQ20]
          n.fcs.overwrite = !w.sb[NEP_F_INS] && w.sb[NEP_F_OVR]; // [RQ22]
          n.fcs.corrupt = w.sb[NEP_F_ERR];
          if (w.sb[NEP_F_ERR] && w.sb[NEP_F_INS]) begin
            cv[0] = ~cv[0]; // [RQ19]
          end
          if (w.sb[NEP_F_ERR] && !w.sb[NEP_F_INS]) begin
            w.data[(int'(nb) - 1) * 8] = ~w.data[(int'(nb) - 1) * 8]; // [RQ19]
          end
          n.fcs.crc = cv;
        end
        n.txcnt = q.txcnt + 16'h1;
      end
      n.mtx = '{sop: tx_sop_i[l], eop: tx_eop_i[l], w: w};
      n.mtx_v = 1'b1;
      if (!whole) begin
        n.tx_ptr = lane_inc(l, half); // [RQ1] [RQ2]
      end else if (tx_eop_i[l]) begin
        n.tx_lock = 1'b0;
        n.tx_ptr = lane_inc(l, half);
      end else begin
        n.tx_lock = 1'b1; // [RQ3]
      end
    end
    // Ready only when the MAC slot will be empty: halves peak rate,
    // but no word is ever taken without room for it.
    n.tx_rdy = 4'h0;
    if (!n.mtx_v) begin
      if (!whole) begin
        n.tx_lane = n.tx_ptr;
        n.tx_rdy[n.tx_ptr] = 1'b1; // [RQ8]
      end else if (n.tx_lock) begin
        n.tx_rdy[n.tx_lane] = 1'b1; // [RQ3]
      end else begin
        for (int i = 0; i < NEP_LANES; i++) begin
          k = n.tx_ptr + 2'(i);
          if (!found && (!half || i < 2) && tx_valid_i[k]) begin
            found = 1'b1;
            n.tx_lane = k;
            n.tx_rdy[k] = 1'b1; // [RQ8]
          end
        end
      end
    end

    // ****************************************************************
    // Receive: MAC to lanes
    // ****************************************************************
    for (int i = 0; i < NEP_LANES; i++) begin
      if (q.rx_v[i] && rx_ready_i[i]) begin // [RQ9] [RQ13]
        n.rx_v[i] = 1'b0;
      end
    end
    if (mac_rx_valid_i && q.mrx_rdy) begin
      l = q.rx_tgt;
      w = mac_rx_i.w; // [RQ14]
      if (mac_rx_i.sop) begin
        w.sb = q.ctrl[NEP_C_RXTS] ? ts_count_i : 30'h0; // [RQ15] [RQ17]
      end else begin
        w.sb[NEP_SEQ_LSB +: NEP_SEQ_W] = q.seq; // [RQ24]
      end
      n.rx_v[l] = 1'b1; // [RQ13]
      n.rx_sop[l] = mac_rx_i.sop;
      n.rx_eop[l] = mac_rx_i.eop;
      n.rx_w[l] = w;
      if (mac_rx_i.eop) begin
        n.seq = q.seq + 5'h1;
        n.rxcnt = q.rxcnt + 16'h1;
      end
      if (!whole) begin
        n.rx_ptr = lane_inc(l, half); // [RQ2]
      end else if (mac_rx_i.eop) begin
        n.rx_lock = 1'b0;
        n.rx_ptr = lane_inc(l, half);
      end else begin
        n.rx_lock = 1'b1;
      end
    end
    // Lanes drain at their own pace, so packets may leave out of order
    found = 1'b0; // [RQ5]
    if (!whole) begin
      n.rx_tgt = n.rx_ptr;
      found = 1'b1;
    end else if (n.rx_lock) begin
      found = 1'b1;
    end else begin
      for (int i = 0; i < NEP_LANES; i++) begin
        k = n.rx_ptr + 2'(i);
        if (!found && (!half || i < 2) && !n.rx_v[k]) begin
          found = 1'b1;
          n.rx_tgt = k; // [RQ4]
        end
      end
    end
    n.mrx_rdy = found && !n.rx_v[n.rx_tgt];
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin // [RQ6] [RQ7]
    if (rst_i) begin
      q <= '0;
      q.ctrl <= NEP_CTRL_RST;
    end else begin
      q <= n;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign tx_ready_o = q.tx_rdy;
  assign mac_tx_o = q.mtx;
  assign mac_tx_valid_o = q.mtx_v;
  assign mac_fcs_o = q.fcs;
  assign mac_rx_ready_o = q.mrx_rdy;
  assign rx_valid_o = q.rx_v;
  assign rx_sop_o = q.rx_sop;
  assign rx_eop_o = q.rx_eop;
  assign rx_src_o = q.src;
  assign rx_data_o = q.rx_w;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic rx_take;
  logic tx_take;
  assign rx_take = mac_rx_valid_i && mac_rx_ready_o;
  assign tx_take = |(tx_ready_o & tx_valid_i);

  property p_tx_onehot;
    $onehot0(tx_ready_o) && !(mac_tx_valid_o && tx_ready_o != 4'h0);
  endproperty
  a_tx_onehot: assert property (p_tx_onehot) // [RQ8]
    else $error("transmit ready offered without room or on two lanes");

  property p_mac_hold;
    mac_tx_valid_o && !mac_tx_ready_i |=>
      mac_tx_valid_o && $stable(mac_tx_o);
  endproperty
  a_mac_hold: assert property (p_mac_hold) // [RQ9]
    else $error("stalled MAC word changed");

  property p_quad_rotate;
    tx_take && !q.ctrl[NEP_C_WHOLE] && !q.ctrl[NEP_C_HALF] |=>
      q.tx_ptr == $past(q.tx_lane) + 2'h1;
  endproperty
  a_quad_rotate: assert property (p_quad_rotate) // [RQ2]
    else $error("quad lane did not advance");

  property p_whole_lock;
    q.ctrl[NEP_C_WHOLE] && q.tx_lock && tx_ready_o != 4'h0 |->
      tx_ready_o[q.tx_lane] && $onehot(tx_ready_o);
  endproperty
  a_whole_lock: assert property (p_whole_lock) // [RQ3]
    else $error("locked lane lost its packet");

  property p_rx_ts;
    rx_take && mac_rx_i.sop && q.ctrl[NEP_C_RXTS] |=>
      rx_sop_o[$past(q.rx_tgt)] &&
      rx_data_o[$past(q.rx_tgt)].sb == $past(ts_count_i);
  endproperty
  a_rx_ts: assert property (p_rx_ts) // [RQ17]
    else $error("arrival time missing on start word");

  property p_rx_seq;
    rx_take && !mac_rx_i.sop |=>
      rx_data_o[$past(q.rx_tgt)].sb[13:9] == $past(q.seq);
  endproperty
  a_rx_seq: assert property (p_rx_seq) // [RQ24]
    else $error("sequence number wrong on receive word");

  property p_rx_deliver;
    rx_take |=> rx_valid_o[$past(q.rx_tgt)] ##0 !$past(rx_valid_o[q.rx_tgt]);
  endproperty
  a_rx_deliver: assert property (p_rx_deliver) // [RQ13]
    else $error("receive word not delivered or overwrote a held word");

  property p_fcs_mode;
    mac_tx_valid_o && mac_tx_o.eop |->
      !(mac_fcs_o.append && mac_fcs_o.overwrite);
  endproperty
  a_fcs_mode: assert property (p_fcs_mode) // [RQ22]
    else $error("append and overwrite both set");

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus answer not one cycle after request");

  c_tx_pkt: cover property (tx_take && |(tx_eop_i & tx_ready_o));
  c_rx_pkt: cover property (rx_take && mac_rx_i.eop);
  c_whole: cover property (q.ctrl[NEP_C_WHOLE] && rx_take && mac_rx_i.sop);
  c_ovr: cover property (mac_tx_valid_o && mac_fcs_o.overwrite);
endmodule

// File: sim/nep_user_sink.sv
// User fabric model that consumes the four receive lanes of the port.
// Assumes the port clock and reset; slow_i stalls every other cycle.
`timescale 1ns/1ps
module nep_user_sink
  import nep_pkg::*;
(
  input wire logic clk_i, // Port clock
  input wire logic rst_i, // Async reset, high
  input wire logic slow_i, // Stall every other cycle
  input wire logic [3:0] valid_i, // Lane word valid
  input wire nep_pkg::nep_word_t [3:0] data_i, // Lane word
  output logic [3:0] ready_o, // Lane ready
  output nep_pkg::nep_word_t [3:0] last_o, // Last word taken per lane
  output logic [7:0] count_o // Words taken
);
  import nep_pkg::*;
  logic toggle_ff;
  // User logic offers ready whenever it can take a word
  always_comb ready_o = {4{~slow_i | toggle_ff}};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      toggle_ff <= 1'b0;
      count_o <= 8'h00;
      last_o <= '0;
    end else begin
      toggle_ff <= ~toggle_ff;
      // Several lanes may hand over in one cycle, so count them all
      count_o <= count_o + 8'($countones(valid_i & ready_o));
      for (int l = 0; l < 4; l++) begin
        if (valid_i[l] && ready_o[l]) begin
          last_o[l] <= data_i[l];
        end
      end
    end
  end
endmodule

// File: sim/test_nep_port.sv
// Self-checking bench for the four-lane packet port.
// Assumes the sink model on the receive lanes; the bench plays the MAC.
`timescale 1ns/1ps
module test_nep_port;
  import nep_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [3:0] tx_valid_i = 4'h0, tx_sop_i = 4'h0, tx_eop_i = 4'h0;
  logic [3:0] tx_ready_o, rx_valid_o, rx_sop_o, rx_eop_o, rx_src_o, rx_rdy;
  nep_word_t [3:0] tx_data_i = '0, rx_data_o, last;
  nep_beat_t mac_tx_o, mac_rx_i = '0;
  nep_beat_t beats[$];
  nep_fcs_t mac_fcs_o, fcs_seen;
  logic mac_tx_valid_o, mac_tx_ready_i = 1'b0, mac_rx_ready_o;
  logic mac_rx_valid_i = 1'b0, sink_slow = 1'b0;
  logic [7:0] sink_count;
  int miscompares = 0, n_compared = 0, cycles = 0;
  localparam logic [29:0] TS = 30'h1234567;

  always #2 sys_clk_i = ~sys_clk_i;

  nep_port u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_valid_i(tx_valid_i),
    .tx_sop_i(tx_sop_i), .tx_eop_i(tx_eop_i),
    .tx_dest_i({4{4'hf}}),
    .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .mac_tx_o(mac_tx_o),
    .mac_tx_valid_o(mac_tx_valid_o), .mac_tx_ready_i(mac_tx_ready_i),
    .mac_fcs_o(mac_fcs_o), .mac_rx_i(mac_rx_i),
    .mac_rx_valid_i(mac_rx_valid_i), .mac_rx_ready_o(mac_rx_ready_o),
    .ts_count_i(TS), .rx_valid_o(rx_valid_o), .rx_sop_o(rx_sop_o),
    .rx_eop_o(rx_eop_o), .rx_src_o(rx_src_o), .rx_data_o(rx_data_o),
    .rx_ready_i(rx_rdy));

  nep_user_sink u_sink (.clk_i(sys_clk_i), .rst_i(rst_i),
    .slow_i(sink_slow), .valid_i(rx_valid_o), .data_i(rx_data_o),
    .ready_o(rx_rdy), .last_o(last), .count_o(sink_count));

  // ********************************************************
  // MAC side: stalls every other cycle, logs accepted words
  // ********************************************************
  always @(posedge sys_clk_i) begin
    mac_tx_ready_i <= ~mac_tx_ready_i;
    if (mac_tx_valid_o && mac_tx_ready_i) begin
      beats.push_back(mac_tx_o);
      if (mac_tx_o.eop) fcs_seen = mac_fcs_o;
    end
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic check(input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic tx_word(input int l, input logic s, e,
                         input logic [29:0] sb, input logic [255:0] d);
    @(posedge sys_clk_i);
    tx_valid_i[l] <= 1'b1;
    tx_sop_i[l] <= s;
    tx_eop_i[l] <= e;
    tx_data_i[l] <= {2'b00, sb, 5'h00, d};
    do @(posedge sys_clk_i); while (tx_ready_o[l] !== 1'b1);
    tx_valid_i[l] <= 1'b0;
  endtask

  // Reflected CRC-32 of the frame, byte 0 in bits 7:0, sent LSB first
  function automatic logic [31:0] crc_ref(input logic [511:0] m,
                                          input int nb);
    logic [31:0] r;
    r = NEP_CRC_INIT;
    for (int i = 0; i < nb * 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ m[i]) ? NEP_CRC_POLY : 32'h0);
    end
    crc_ref = ~r;
  endfunction

  // Two-word packet: timestamp on the start word, flags on the end word
  task automatic tx_pkt(input int a, b, input logic [29:0] fl,
                        input logic ap, ov, input int nb,
                        input logic [31:0] mask);
    int n;
    n = beats.size();
    tx_word(a, 1'b1, 1'b0, 30'h100 + a, 256'h11 + a);
    tx_word(b, 1'b0, 1'b1, fl, 256'h22);
    while (beats.size() < n + 2) @(posedge sys_clk_i);
    check(beats[n].sop, 1'b1);
    check(beats[n].w.data[63:0], 64'h11 + a);
    check(beats[n + 1].eop, 1'b1);
    check(beats[n + 1].w.data[63:0], 64'h22);
    check(fcs_seen.ts, 30'h100 + a);
    check(fcs_seen.onestep, 1'b0);
    check(fcs_seen.append, ap);
    check(fcs_seen.overwrite, ov);
    check(fcs_seen.corrupt, fl[NEP_F_ERR]);
    check(fcs_seen.crc, crc_ref({256'h22, 256'h11 + a}, nb) ^ mask);
  endtask

  task automatic rx_beat(input logic s, e, input logic [29:0] sb,
                         input logic [255:0] d);
    @(posedge sys_clk_i);
    mac_rx_valid_i <= 1'b1;
    mac_rx_i <= {s, e, 2'b00, sb, 5'h04, d};
    do @(posedge sys_clk_i); while (mac_rx_ready_o !== 1'b1);
    mac_rx_valid_i <= 1'b0;
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic test_regs;
    wb_xfer(1'b0, NEP_REG_CTRL, 32'h0, rd);
    check(rd, 32'h0);
    wb_xfer(1'b1, NEP_REG_CTRL, 32'h4, rd);
    wb_xfer(1'b0, NEP_REG_CTRL, 32'h0, rd);
    check(rd[3:0], 4'h4);
    wb_xfer(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
  endtask

  // Lane order is forced by tx_word: a wrong lane never gets ready
  task automatic test_quad_tx;
    tx_pkt(0, 1, 30'h1 << NEP_F_INS, 1'b1, 1'b0, 64, 32'h0);
    tx_pkt(2, 3, (30'h1 << NEP_F_OVR) | (30'h1 << NEP_F_INV), 1'b0,
           1'b1, 60, 32'hffffffff);
    tx_pkt(0, 1, (30'h1 << NEP_F_INS) | (30'h1 << NEP_F_OVR), 1'b1,
           1'b0, 64, 32'h0);
  endtask

  task automatic test_rx;
    rx_beat(1'b1, 1'b0, 30'h3fffffff, 256'ha1);
    rx_beat(1'b0, 1'b1, 30'h0, 256'ha2);
    sink_slow <= 1'b1;
    rx_beat(1'b1, 1'b0, 30'h0, 256'hb1);
    rx_beat(1'b0, 1'b1, 30'h0, 256'hb2);
    while (sink_count < 8'd4) @(posedge sys_clk_i);
    check(last[0].sb, TS);
    check(last[1].data[63:0], 64'ha2);
    check(last[1].mod, 5'h04);
    check(last[1].sb[13:9], 5'h00);
    check(last[2].data[63:0], 64'hb1);
    check(last[3].sb[13:9], 5'h01);
    check(rx_src_o, 4'hf);
  endtask

  task automatic test_whole;
    wb_xfer(1'b1, NEP_REG_CTRL, 32'h1, rd);
    tx_pkt(3, 3, 30'h1 << NEP_F_INS, 1'b1, 1'b0, 64, 32'h0);
    wb_xfer(1'b0, NEP_REG_STAT, 32'h0, rd);
    check(rd[1:0], 2'h0);
    tx_pkt(1, 1, (30'h1 << NEP_F_ERR) | (30'h1 << NEP_F_INS), 1'b1, 1'b0,
           64, 32'h1);
    wb_xfer(1'b0, NEP_REG_STAT, 32'h0, rd);
    check(rd[1:0], 2'h2);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_quad_tx();
    test_rx();
    test_whole();
    print_verdict();
  end
endmodule
